// File: logic/ddrlv_cfg.svh
// constants for the leveling, per-device and reference control block
`ifndef DDRLV_CFG_SVH
`define DDRLV_CFG_SVH
// clock rate and exit settle time
`define DDRLV_CLK_MHZ 20
`define DDRLV_TMOD_NS 200
`define DDRLV_TMOD_CYC ((`DDRLV_TMOD_NS * `DDRLV_CLK_MHZ + 999) / 1000)
// mode register numbers
`define DDRLV_MR1 3'h1
`define DDRLV_MR3 3'h3
`define DDRLV_MR6 3'h6
// field positions
`define DDRLV_MR1_WL 7
`define DDRLV_MR1_QOFF 12
`define DDRLV_MR3_PDA 4
`define DDRLV_MR6_CAL 7
`define DDRLV_MR6_RANGE 6
// reset value of every mode register
`define DDRLV_MR_RST 14'h0000
// register port offsets
`define DDRLV_REG_CTRL 8'h00
`define DDRLV_REG_STAT 8'h04
`define DDRLV_REG_MR1 8'h08
`define DDRLV_REG_MR3 8'h0C
`define DDRLV_REG_MR6 8'h10
`define DDRLV_REG_VREF 8'h14
// reference level in thousandths of a percent of the supply
`define DDRLV_VREF_R1_BASE 17'h0EA60
`define DDRLV_VREF_R2_BASE 17'h0AFC8
`define DDRLV_VREF_STEP 17'h0028A
`endif

// File: logic/ddrlv_pkg.sv
// types for the leveling, per-device and reference control block
package ddrlv_pkg;
    // dq drive phase around write leveling
    typedef enum logic [1:0] {DQ_IDLE, DQ_UNDEF_IN, DQ_FEEDBACK, DQ_UNDEF_OUT} ddrlv_dq_t;
    // per-device qualification of a pending mode register set
    typedef enum logic [0:0] {PD_IDLE, PD_ARMED} ddrlv_pda_t;
endpackage

// File: logic/ddrlv_sync.sv
// two-flop synchroniser with edge pulses taken after the second flop
`timescale 1ns/1ps
module ddrlv_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_r, stage_r, prev_r; // meta_r feeds stage_r only
    logic metaNxt, stageNxt, prevNxt;

    // next values of the chain
    always_comb begin
        metaNxt = rstn ? pinIn : 1'b0;
        stageNxt = rstn ? meta_r : 1'b0;
        prevNxt = rstn ? stage_r : 1'b0;
    end

    // register the chain
    always_ff @(posedge clock) begin
        meta_r <= metaNxt;
        stage_r <= stageNxt;
        prev_r <= prevNxt;
    end

    assign level = stage_r;
    assign rise = stage_r & ~prev_r;
    assign fall = ~stage_r & prev_r;
endmodule

// File: logic/ddrlv_timer.sv
// down counter that stays busy for a loaded number of cycles
`timescale 1ns/1ps
module ddrlv_timer (
    input wire logic clock,
    input wire logic rstn,
    input wire logic load,
    input wire logic [7:0] count,
    output logic busy
);
    logic [7:0] cnt_r; // cycles still to wait
    logic [7:0] cntNxt;

    // reload wins over counting down
    always_comb begin
        cntNxt = cnt_r;
        if (!rstn) begin
            cntNxt = 8'h00;
        end else if (load) begin
            cntNxt = count;
        end else if (cnt_r != 8'h00) begin
            cntNxt = cnt_r - 8'h01;
        end
    end

    // register the count
    always_ff @(posedge clock) begin
        cnt_r <= cntNxt;
    end

    assign busy = (cnt_r != 8'h00);
endmodule

// File: logic/ddrlv_ctrl.sv
// write leveling, per-device addressing and dq reference control
// Behaviour
// - mr1 bit 7 enters and leaves leveling
// - leveling odt switches only strobe termination
// - mr1 bit 12 disables the outputs
// - exit set may update 12..8, 2..1
// - dq undefined on entry until feedback
// - strobe rise samples clock onto all dq
// - dq undefined until settle after exit
// - mr3 bit 4 enables per-device, resets 0
// - dq0 low executes set, high ignores
// - dq0 sampled first fall or second rise
// - exit clears bit 4, rewrites whole mr3
// - mr6 enables calibration, range, level code
// - each code step is fixed size
// - mr6 write without bit 7 keeps level
// - last level before exit is used
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "ddrlv_cfg.svh"
module ddrlv_ctrl import ddrlv_pkg::*; (
    input wire logic clock,
    input wire logic rstn,
    input wire logic mrsValid,
    input wire logic [2:0] mrsSel,
    input wire logic [13:0] mrsAddr,
    input wire logic dqsPin,
    input wire logic ckPin,
    input wire logic odtPin,
    input wire logic dq0Pin,
    output logic [7:0] dqOut,
    output logic dqOe,
    output logic rttDqsOn,
    output logic rttDqOn,
    output logic wlMode,
    output logic pdaMode,
    output logic vrefCalMode,
    output logic vrefRange,
    output logic [5:0] vrefCode,
    output logic [16:0] vrefLevel,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // synchronised pins
    logic dqsLvl, dqsRise, dqsFall, ckLvl, odtLvl, dq0Lvl;
    logic timerBusy; // settle time after leveling exit

    // pins come from the controller's domain, so all pass two flops
    ddrlv_sync uDqs (.clock(clock), .rstn(rstn), .pinIn(dqsPin),
        .level(dqsLvl), .rise(dqsRise), .fall(dqsFall));
    ddrlv_sync uCk (.clock(clock), .rstn(rstn), .pinIn(ckPin),
        .level(ckLvl), .rise(), .fall());
    ddrlv_sync uOdt (.clock(clock), .rstn(rstn), .pinIn(odtPin),
        .level(odtLvl), .rise(), .fall());
    ddrlv_sync uDq0 (.clock(clock), .rstn(rstn), .pinIn(dq0Pin),
        .level(dq0Lvl), .rise(), .fall());

    // mode register and reference state
    logic [13:0] mr1_r, mr3_r, mr6_r;
    logic [13:0] mr1Nxt, mr3Nxt, mr6Nxt;
    logic [6:0] vref_r, vrefNxt; // applied range and code
    logic sampleFall_r, sampleFallNxt; // pda sample edge choice
    // pending per-device command
    ddrlv_pda_t pda_r, pdaNxt;
    logic [2:0] heldSel_r, heldSelNxt;
    logic [13:0] heldAddr_r, heldAddrNxt;
    logic [1:0] riseCnt_r, riseCntNxt; // strobe rises since arming
    // command actually applied this cycle
    logic execute, pdaSample;
    logic [2:0] execSel;
    logic [13:0] execAddr;

    assign wlMode = mr1_r[`DDRLV_MR1_WL];
    assign pdaMode = mr3_r[`DDRLV_MR3_PDA];
    assign vrefCalMode = mr6_r[`DDRLV_MR6_CAL];

    // per-device capture: dq0 taken at the chosen strobe edge
    always_comb begin
        pdaNxt = pda_r;
        heldSelNxt = heldSel_r;
        heldAddrNxt = heldAddr_r;
        riseCntNxt = riseCnt_r;
        pdaSample = 1'b0;
        case (pda_r)
            PD_IDLE: begin
                // in per-device mode a set waits for its dq0 burst
                if (mrsValid && pdaMode) begin
                    pdaNxt = PD_ARMED;
                    heldSelNxt = mrsSel;
                    heldAddrNxt = mrsAddr;
                    riseCntNxt = 2'h0;
                end
            end
            PD_ARMED: begin
                if (dqsRise && riseCnt_r != 2'h3) begin
                    riseCntNxt = riseCnt_r + 2'h1;
                end
                // first falling or second rising edge of the burst
                if (sampleFall_r) begin
                    pdaSample = dqsFall && riseCnt_r != 2'h0;
                end else begin
                    pdaSample = dqsRise && riseCnt_r == 2'h1;
                end
                if (pdaSample) begin
                    pdaNxt = PD_IDLE;
                end
            end
            default: pdaNxt = PD_IDLE;
        endcase
        if (!rstn) begin
            pdaNxt = PD_IDLE;
        end
    end

    // dq0 low executes the held set, high drops it
    assign execute = pdaMode ? (pdaSample && !dq0Lvl) : mrsValid;
    assign execSel = pdaMode ? heldSel_r : mrsSel;
    assign execAddr = pdaMode ? heldAddr_r : mrsAddr;

    // mode register update rules
    always_comb begin
        mr1Nxt = mr1_r;
        mr3Nxt = mr3_r;
        mr6Nxt = mr6_r;
        vrefNxt = vref_r;
        sampleFallNxt = sampleFall_r;
        if (regWr && regAddr == `DDRLV_REG_CTRL) begin
            sampleFallNxt = regWdata[0];
        end
        if (execute) begin
            case (execSel)
                `DDRLV_MR1: begin
                    if (!wlMode) begin
                        mr1Nxt = execAddr;
                    end else if (execAddr[`DDRLV_MR1_WL]) begin
                        // inside leveling only the output-off bit moves
                        mr1Nxt[`DDRLV_MR1_QOFF] = execAddr[`DDRLV_MR1_QOFF];
                    end else begin
                        // the exit set may also carry 12..8 and 2..1
                        mr1Nxt[12:8] = execAddr[12:8];
                        mr1Nxt[`DDRLV_MR1_WL] = 1'b0;
                        mr1Nxt[2:1] = execAddr[2:1];
                    end
                end
                // the whole register is rewritten, exit included
                `DDRLV_MR3: mr3Nxt = execAddr;
                `DDRLV_MR6: begin
                    mr6Nxt[`DDRLV_MR6_CAL] = execAddr[`DDRLV_MR6_CAL];
                    if (execAddr[`DDRLV_MR6_CAL]) begin
                        mr6Nxt[6:0] = execAddr[6:0];
                        // the last level written stays applied on exit
                        vrefNxt = execAddr[6:0];
                    end
                    // with bit 7 clear, range and level are kept
                end
                default: mr6Nxt = mr6_r; // other register numbers ignored
            endcase
        end
        if (!rstn) begin
            mr1Nxt = `DDRLV_MR_RST;
            mr3Nxt = `DDRLV_MR_RST;
            mr6Nxt = `DDRLV_MR_RST;
            vrefNxt = 7'h00;
            sampleFallNxt = 1'b0;
        end
    end

    // register mode and capture state
    always_ff @(posedge clock) begin
        mr1_r <= mr1Nxt;
        mr3_r <= mr3Nxt;
        mr6_r <= mr6Nxt;
        vref_r <= vrefNxt;
        sampleFall_r <= sampleFallNxt;
        pda_r <= pdaNxt;
        heldSel_r <= heldSelNxt;
        heldAddr_r <= heldAddrNxt;
        riseCnt_r <= riseCntNxt;
    end

    assign vrefRange = vref_r[`DDRLV_MR6_RANGE];
    assign vrefCode = vref_r[5:0];
    // one fixed step per code, added to the range floor
    assign vrefLevel = (vrefRange ? `DDRLV_VREF_R2_BASE : `DDRLV_VREF_R1_BASE)
        + 17'(vrefCode * `DDRLV_VREF_STEP);

    // leveling dq phase and feedback
    ddrlv_dq_t dq_r, dqNxt;
    logic fbk_r, fbkNxt; // last sampled clock level
    logic dqOe_r, dqOeNxt;
    logic rttDqs_r, rttDq_r, rttDqsNxt, rttDqNxt;
    logic wlEnter, wlExit;

    assign wlEnter = !mr1_r[`DDRLV_MR1_WL] && mr1Nxt[`DDRLV_MR1_WL];
    assign wlExit = mr1_r[`DDRLV_MR1_WL] && !mr1Nxt[`DDRLV_MR1_WL];

    ddrlv_timer uMod (.clock(clock), .rstn(rstn), .load(wlExit),
        .count(8'(`DDRLV_TMOD_CYC)), .busy(timerBusy));

    // undefined on entry, feedback after a strobe, undefined after exit
    always_comb begin
        dqNxt = dq_r;
        fbkNxt = fbk_r;
        // each strobe rise in leveling loads the clock level
        if (wlMode && dqsRise) begin
            fbkNxt = ckLvl;
        end
        case (dq_r)
            DQ_IDLE: if (wlEnter) dqNxt = DQ_UNDEF_IN;
            DQ_UNDEF_IN: begin
                if (wlExit) begin
                    dqNxt = DQ_UNDEF_OUT;
                end else if (dqsRise) begin
                    dqNxt = DQ_FEEDBACK;
                end
            end
            DQ_FEEDBACK: if (wlExit) dqNxt = DQ_UNDEF_OUT;
            DQ_UNDEF_OUT: begin
                // undefined until settle time after the exit set
                if (wlEnter) begin
                    dqNxt = DQ_UNDEF_IN;
                end else if (!timerBusy) begin
                    dqNxt = DQ_IDLE;
                end
            end
            default: dqNxt = DQ_IDLE;
        endcase
        // undefined phases are shown as released pins
        dqOeNxt = (dqNxt == DQ_FEEDBACK) && !mr1Nxt[`DDRLV_MR1_QOFF];
        // leveling lets odt reach only the strobe pair
        rttDqsNxt = odtLvl;
        rttDqNxt = odtLvl && !mr1Nxt[`DDRLV_MR1_WL];
        if (!rstn) begin
            dqNxt = DQ_IDLE;
            fbkNxt = 1'b0;
            dqOeNxt = 1'b0;
            rttDqsNxt = 1'b0;
            rttDqNxt = 1'b0;
        end
    end

    // register dq phase and pin drivers
    always_ff @(posedge clock) begin
        dq_r <= dqNxt;
        fbk_r <= fbkNxt;
        dqOe_r <= dqOeNxt;
        rttDqs_r <= rttDqsNxt;
        rttDq_r <= rttDqNxt;
    end

    // feedback sits on every dq bit; no read strobe is driven
    assign dqOut = {8{fbk_r}};
    assign dqOe = dqOe_r;
    assign rttDqsOn = rttDqs_r;
    assign rttDqOn = rttDq_r;

    // register port read, data valid the cycle after the strobe
    logic [31:0] rdata_r, rdataNxt;
    always_comb begin
        rdataNxt = 32'h00000000;
        if (regRd && rstn) begin
            case (regAddr)
                `DDRLV_REG_CTRL: rdataNxt = {31'h0, sampleFall_r};
                `DDRLV_REG_STAT: rdataNxt = {24'h0, dq_r, timerBusy, pda_r,
                    vrefCalMode, mr1_r[`DDRLV_MR1_QOFF], pdaMode, wlMode};
                `DDRLV_REG_MR1: rdataNxt = {18'h0, mr1_r};
                `DDRLV_REG_MR3: rdataNxt = {18'h0, mr3_r};
                `DDRLV_REG_MR6: rdataNxt = {18'h0, mr6_r};
                `DDRLV_REG_VREF: rdataNxt = {15'h0, vrefLevel};
                default: rdataNxt = 32'h00000000; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clock) begin
        rdata_r <= rdataNxt;
    end
    assign regRdata = rdata_r;

    // checks
    AST_WL_ENTRY: assert property (mrsValid && !pdaMode && !wlMode &&
        mrsSel == `DDRLV_MR1 && mrsAddr[`DDRLV_MR1_WL] |=> wlMode)
        else $error("leveling not entered");
    AST_TERM_WL: assert property ($past(wlMode) |-> !rttDqOn)
        else $error("data termination followed odt in leveling");
    AST_QOFF: assert property (mr1_r[`DDRLV_MR1_QOFF] |-> !dqOe)
        else $error("outputs driven while disabled");
    AST_WL_KEEP: assert property ($past(wlMode) && wlMode |->
        mr1_r[11:0] == $past(mr1_r[11:0]) && mr1_r[13] == $past(mr1_r[13]))
        else $error("mr1 changed inside leveling");
    AST_UNDEF_IN: assert property ($rose(wlMode) |-> !dqOe)
        else $error("dq driven at leveling entry");
    AST_FBK: assert property (wlMode && dqsRise |=>
        dqOut == {8{$past(ckLvl)}})
        else $error("feedback does not match sampled clock");
    AST_UNDEF_OUT: assert property ($fell(wlMode) |-> (dq_r == DQ_UNDEF_OUT && !dqOe) [*4])
        else $error("dq driven before settle time");
    // own disable, since the default one would mask every reset cycle
    AST_PDA_RST: assert property (@(posedge clock) disable iff (1'b0) !rstn |=> !pdaMode)
        else $error("per-device mode not cleared by reset");
    AST_PDA_SKIP: assert property (pdaMode && pdaSample && dq0Lvl |=>
        $stable(mr1_r) && $stable(mr3_r) && $stable(mr6_r))
        else $error("set executed with dq0 high");
    AST_VREF_HOLD: assert property (mrsValid && !pdaMode &&
        mrsSel == `DDRLV_MR6 && !mrsAddr[`DDRLV_MR6_CAL] |=> $stable(vref_r))
        else $error("reference changed with calibration off");
    COV_FBK: cover property (dq_r == DQ_UNDEF_IN ##[1:200] dqOe);
    COV_PDA: cover property (pdaMode && pdaSample && !dq0Lvl);
    COV_VREF: cover property ($fell(vrefCalMode));
endmodule

// File: test/ddrlv_host_model.sv
// controller-side pin model: free ck, strobe pulses, odt and dq0
`timescale 1ns/1ps
module ddrlv_host_model (
    input wire logic clock,
    output logic ckPin,
    output logic dqsPin,
    output logic odtPin,
    output logic dq0Pin
);
    // ck runs free, phase unrelated to the block clock
    initial begin
        ckPin = 1'b0;
        dqsPin = 1'b0;
        odtPin = 1'b0;
        dq0Pin = 1'b1;
        #37;
        forever #200 ckPin = ~ckPin;
    end

    // one strobe pulse; rise placed early in a ck phase so the level is unambiguous
    task automatic pulse(input int gap, output logic lvl);
        @(ckPin);
        repeat (2) @(posedge clock);
        dqsPin <= 1'b1;
        lvl = ckPin;
        repeat (8) @(posedge clock);
        dqsPin <= 1'b0;
        // variable idle time stands in for a delay step
        repeat (8 + gap) @(posedge clock);
    endtask

    // two-pulse burst, dq0 held throughout, then released to the inverse
    task automatic burst(input logic v);
        logic l;
        dq0Pin <= v;
        pulse(0, l);
        pulse(0, l);
        dq0Pin <= ~v;
        // spacing before the next set
        repeat (4) @(posedge clock);
    endtask

    // odt change, then time for the termination to follow
    task automatic odt(input logic v);
        @(posedge clock);
        odtPin <= v;
        repeat (8) @(posedge clock);
    endtask
endmodule

// File: test/tb_top.sv
// self-checking bench for the leveling, per-device and reference block
`timescale 1ns/1ps
`include "ddrlv_cfg.svh"
module tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic mrsValid = 1'b0;
    logic [2:0] mrsSel = 3'h0;
    logic [13:0] mrsAddr = 14'h0000;
    logic ckPin, dqsPin, odtPin, dq0Pin;
    logic [7:0] dqOut;
    logic dqOe, rttDqsOn, rttDqOn, wlMode, pdaMode, vrefCalMode, vrefRange;
    logic [5:0] vrefCode;
    logic [16:0] vrefLevel;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    int error_cnt = 0;
    int checks = 0;
    integer seed = 32'h2640;
    logic [31:0] expQ[$]; // expected read data, oldest first
    logic rdPend = 1'b0;
    logic [13:0] mr6Exp;
    logic [16:0] lvlExp;
    logic [5:0] code;
    logic lvl;

    always #25 clock = ~clock;

    ddrlv_ctrl u_ddrlv_ctrl (.clock(clock), .rstn(rstn), .mrsValid(mrsValid),
        .mrsSel(mrsSel), .mrsAddr(mrsAddr), .dqsPin(dqsPin), .ckPin(ckPin),
        .odtPin(odtPin), .dq0Pin(dq0Pin), .dqOut(dqOut), .dqOe(dqOe),
        .rttDqsOn(rttDqsOn), .rttDqOn(rttDqOn), .wlMode(wlMode), .pdaMode(pdaMode),
        .vrefCalMode(vrefCalMode), .vrefRange(vrefRange), .vrefCode(vrefCode),
        .vrefLevel(vrefLevel), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

    ddrlv_host_model u_ddrlv_host_model (.clock(clock), .ckPin(ckPin),
        .dqsPin(dqsPin), .odtPin(odtPin), .dq0Pin(dq0Pin));

    // single compare for every kind of result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        if (rdPend) begin
            chk(regRdata, expQ.pop_front());
        end
        rdPend <= regRd;
    end

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back(exp);
        @(posedge clock);
        regRd <= 1'b0;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    // one-cycle mode set, then time for the outputs to settle
    task automatic mrs(input logic [2:0] s, input logic [13:0] a);
        @(posedge clock);
        mrsValid <= 1'b1;
        mrsSel <= s;
        mrsAddr <= a;
        @(posedge clock);
        mrsValid <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    task automatic print_verdict();
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        // reset state, unmapped place reads zero
        reg_rd(`DDRLV_REG_STAT, 32'h0);
        reg_rd(`DDRLV_REG_MR3, 32'h0);
        reg_rd(8'h18, 32'h0);
        // normal mode: data termination follows odt
        u_ddrlv_host_model.odt(1'b1);
        chk(32'(rttDqOn), 32'h1);
        mrs(`DDRLV_MR1, 14'h0080);
        chk(32'(wlMode), 32'h1);
        chk(32'(dqOe), 32'h0);
        repeat (4) @(posedge clock);
        chk(32'(rttDqOn), 32'h0);
        chk(32'(rttDqsOn), 32'h1);
        // strobe waits until termination has settled
        for (int i = 0; i < 6; i++) begin
            u_ddrlv_host_model.pulse($random(seed) & 7, lvl);
            chk(32'(dqOut), 32'({8{lvl}}));
            chk(32'(dqOe), 32'h1);
        end
        // inside leveling only the output-disable bit may change
        mrs(`DDRLV_MR1, 14'h1088);
        chk(32'(dqOe), 32'h0);
        reg_rd(`DDRLV_REG_MR1, 32'h1080);
        u_ddrlv_host_model.odt(1'b0);
        chk(32'(rttDqsOn), 32'h0);
        mrs(`DDRLV_MR1, 14'h0F0E);
        chk(32'(wlMode), 32'h0);
        chk(32'(dqOe), 32'h0);
        reg_rd(`DDRLV_REG_MR1, 32'h0F06);
        // settle time after the exit set before the next command
        repeat (`DDRLV_TMOD_CYC) @(posedge clock);
        // per-device mode, both sample edges, dq0 low and high
        mrs(`DDRLV_MR3, 14'h0010);
        chk(32'(pdaMode), 32'h1);
        mr6Exp = 14'h0000;
        for (int e = 0; e < 2; e++) begin
            reg_wr(`DDRLV_REG_CTRL, 32'(e));
            for (int v = 0; v < 2; v++) begin
                code = 6'($random(seed));
                mrs(`DDRLV_MR6, 14'h0080 | 14'(code));
                u_ddrlv_host_model.burst(v[0]);
                if (v == 0) begin
                    mr6Exp = 14'h0080 | 14'(code);
                end
                reg_rd(`DDRLV_REG_MR6, 32'(mr6Exp));
            end
        end
        mrs(`DDRLV_MR3, 14'h0008);
        u_ddrlv_host_model.burst(1'b0);
        chk(32'(pdaMode), 32'h0);
        reg_rd(`DDRLV_REG_MR3, 32'h0008);
        // reference range and code, then exit keeping the last setting
        for (int i = 0; i < 4; i++) begin
            code = 6'($random(seed));
            mr6Exp = 14'h0080 | (14'(i & 1) << 6) | 14'(code);
            lvlExp = ((i & 1) ? `DDRLV_VREF_R2_BASE : `DDRLV_VREF_R1_BASE)
                + 17'(code) * `DDRLV_VREF_STEP;
            mrs(`DDRLV_MR6, mr6Exp);
            chk(32'(vrefCalMode), 32'h1);
            chk(32'(vrefRange), 32'(i & 1));
            chk(32'(vrefCode), 32'(code));
            chk(32'(vrefLevel), 32'(lvlExp));
            reg_rd(`DDRLV_REG_VREF, 32'(lvlExp));
            mrs(`DDRLV_MR6, 14'($random(seed)) & 14'h007F);
            chk(32'(vrefCalMode), 32'h0);
            chk(32'(vrefCode), 32'(code));
            chk(32'(vrefLevel), 32'(lvlExp));
            reg_rd(`DDRLV_REG_MR6, 32'(mr6Exp & 14'h3F7F));
        end
        repeat (4) @(posedge clock);
        print_verdict();
    end
endmodule
